/* rtl/clkovr_cfg.svh */
// Register offsets, field positions, reset values for the clock override and error inject bank.
// Assumes inclusion by bare name from rtl files.
`ifndef CLKOVR_CFG_SVH
`define CLKOVR_CFG_SVH
`define ADDR_OSC_DIV 8'h29
`define ADDR_CRC_CNT 8'h2A
`define ADDR_ERR_INJ 8'h2D
`define ADDR_PLL_OVR 8'h35
`define RST_OSC_DIV 8'h06
`define RST_CRC_CNT 8'h00
`define RST_ERR_INJ 8'h00
`define RST_PLL_OVR 8'h01
`define BIT_DIV4 5
`define BIT_FORCE_ONE 7
`define BIT_STRAP 3
`define BIT_LOCK_EXT 1
`define BIT_LOCK_OSC 0
`define OVR_RW_MASK 8'hF3
`define BIST_MSB 6
`define CRC_MAX 8'hFF
`define ZERO8 8'h00
`define ZERO7 7'h00
`define ONE7 7'h01
`define ONE2 2'h1
`define ONE8 8'h01
// The strap is taken on the third edge after release, once the synchroniser holds the pin
`define STRAP_TAKE 2'h2
`define STRAP_DONE 2'h3
`endif

/* rtl/clkovr_pkg.sv */
// Types shared by the clock override and error inject bank.
// Assumes no surroundings beyond the tool's package support.
`default_nettype none
package clkovr_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    SRC_PIXEL = 2'b00,
    SRC_EXT = 2'b01,
    SRC_OSC = 2'b10
  } pll_src_t;
endpackage
`default_nettype wire

/* rtl/oscillator_divider_control.sv */
// Divides the oscillator clock by two or four, output from a flip-flop.
// Assumes the oscillator is the module clock.
`include "clkovr_cfg.svh"
`default_nettype none
module oscillator_divider_control (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic DIV4_IN,
  input wire logic EN_IN,
  output logic CLK_OUT
);
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic next_clk;
  assign next_cnt = cnt + `ONE2;
  // Divide by four toggles on the upper counter bit, by two on the lower
  assign next_clk = EN_IN & (DIV4_IN ? next_cnt[1] : next_cnt[0]);
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cnt <= 2'h0;
      CLK_OUT <= 1'b0;
    end else begin
      cnt <= next_cnt;
      CLK_OUT <= next_clk;
    end
  end
endmodule
`default_nettype wire

/* rtl/clkovr_regs.sv */
// Clock override, oscillator divider and forward channel error injection registers.
// Assumes a local control port decoder giving byte address, write and read strobes.
`include "clkovr_cfg.svh"
`default_nettype none
module clkovr_regs
  import clkovr_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire clkovr_pkg::byte_t ADDR_IN,
  input wire clkovr_pkg::byte_t WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic PLL_OVERRIDE_IN,
  input wire logic BIST_ACTIVE_IN,
  input wire logic STRAP_EXT_OSC_IN,
  input wire logic BC_CRC_ERR_IN,
  input wire logic FRAME_START_IN,
  output var clkovr_pkg::byte_t RDATA_OUT,
  output logic ERR_INJECT_OUT,
  output var clkovr_pkg::pll_src_t PLL_SRC_OUT,
  output logic AUX_OUTPUT_PIN_TWO_OUT
);
  import clkovr_pkg::*;

  byte_t osc_div;
  byte_t crc_cnt;
  byte_t inj;
  byte_t pll_ovr;
  logic [6:0] bist_left;
  logic bist_d;
  logic strap_s1;
  logic strap_s2;
  logic bist_s1;
  logic bist_s2;
  logic ovr_s1;
  logic ovr_s2;
  logic strap_ext;
  // Counts edges after release until the strap synchroniser holds the pin level
  logic [1:0] strap_wait;

  function automatic logic hit(input byte_t a, input byte_t b);
    hit = (a == b);
  endfunction

  // The strap, self-test and override inputs pass two flops before any use; frame start and CRC error are used directly
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      bist_s1 <= 1'b0;
      bist_s2 <= 1'b0;
      ovr_s1 <= 1'b0;
      ovr_s2 <= 1'b0;
    end else begin
      strap_s1 <= STRAP_EXT_OSC_IN;
      strap_s2 <= strap_s1;
      bist_s1 <= BIST_ACTIVE_IN;
      bist_s2 <= bist_s1;
      ovr_s1 <= PLL_OVERRIDE_IN;
      ovr_s2 <= ovr_s1;
    end
  end

  // Taking the strap on the first edge would latch the synchroniser's reset value,
  // so it waits until both flops hold the pin
  wire strap_done = (strap_wait == `STRAP_DONE);
  wire strap_take = (strap_wait == `STRAP_TAKE);
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      strap_wait <= 2'h0;
    end else if (!strap_done) begin
      strap_wait <= strap_wait + `ONE2;
    end
  end

  // Later strap changes are ignored: the mode is fixed until the next reset
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      strap_ext <= 1'b0;
    end else if (strap_take) begin
      strap_ext <= strap_s2;
    end
  end

  // One decode per register, shared by the write enables and the read mux; the CRC count decode only feeds the read mux
  wire sel_div = hit(ADDR_IN, `ADDR_OSC_DIV);
  wire sel_crc = hit(ADDR_IN, `ADDR_CRC_CNT);
  wire sel_inj = hit(ADDR_IN, `ADDR_ERR_INJ);
  wire sel_ovr = hit(ADDR_IN, `ADDR_PLL_OVR);
  wire wr_div = WR_IN & sel_div;
  wire wr_inj = WR_IN & sel_inj;
  wire wr_ovr = WR_IN & sel_ovr;
  wire bist_rise = bist_s2 & ~bist_d;
  wire force_one = inj[`BIT_FORCE_ONE];
  // One-shot injection is a normal-mode feature; it waits for a frame outside self test
  wire one_shot_fire = force_one & ~bist_s2 & FRAME_START_IN;
  wire bist_fire = bist_s2 & FRAME_START_IN & (bist_left != `ZERO7);
  wire next_inject = one_shot_fire | bist_fire;
  // Saturates instead of wrapping, so a very noisy test never reads back small
  wire crc_inc = bist_s2 & BC_CRC_ERR_IN & (crc_cnt != `CRC_MAX);

  // Next values are picked here so each register flop below is a plain load
  byte_t next_osc_div;
  byte_t next_pll_ovr;
  byte_t next_inj;
  assign next_osc_div = wr_div ? WDATA_IN : osc_div;
  // Bits 3 and 2 are never stored; bit 3 is merged in from the strap on reads
  assign next_pll_ovr = wr_ovr ? (WDATA_IN & `OVR_RW_MASK) : pll_ovr;
  // A host write in the firing cycle wins over the self-clear, so a new request is kept
  assign next_inj = wr_inj ? WDATA_IN :
                    one_shot_fire ? (inj & ~(`ONE8 << `BIT_FORCE_ONE)) : inj;

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      osc_div <= `RST_OSC_DIV;
    end else begin
      osc_div <= next_osc_div;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pll_ovr <= `RST_PLL_OVR;
    end else begin
      pll_ovr <= next_pll_ovr;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      inj <= `RST_ERR_INJ;
    end else begin
      inj <= next_inj;
    end
  end

  // Self-test error budget is loaded when the test starts, so mid-test writes do not count
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      bist_d <= 1'b0;
      bist_left <= `ZERO7;
      crc_cnt <= `RST_CRC_CNT;
    end else begin
      bist_d <= bist_s2;
      if (bist_rise) begin
        bist_left <= inj[`BIST_MSB:0];
        crc_cnt <= `RST_CRC_CNT;
      end else begin
        if (bist_fire)
          bist_left <= bist_left - `ONE7;
        if (crc_inc)
          crc_cnt <= crc_cnt + 8'h01;
      end
    end
  end

  // Clock source select: internal osc wins over external, both need the override
  wire lock_osc = pll_ovr[`BIT_LOCK_OSC];
  wire lock_ext = pll_ovr[`BIT_LOCK_EXT];
  // The override arrives through the synchroniser, so a change shows three edges later
  wire want_osc = ovr_s2 & lock_osc;
  wire want_ext = ovr_s2 & ~lock_osc & lock_ext;
  pll_src_t next_src;
  assign next_src = want_osc ? SRC_OSC :
                    want_ext ? SRC_EXT : SRC_PIXEL;

  byte_t ovr_read;
  assign ovr_read = pll_ovr | ({7'h00, strap_ext} << `BIT_STRAP);
  byte_t next_rdata;
  // Read data holds between reads so a slow host may take it late; reserved reads give zero
  assign next_rdata = !RD_IN ? RDATA_OUT :
                      sel_div ? osc_div :
                      sel_crc ? crc_cnt :
                      sel_inj ? inj :
                      sel_ovr ? ovr_read : `ZERO8;

  // One flop per output, so no decode path reaches a pin
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= `ZERO8;
    end else begin
      RDATA_OUT <= next_rdata;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ERR_INJECT_OUT <= 1'b0;
    end else begin
      ERR_INJECT_OUT <= next_inject;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PLL_SRC_OUT <= SRC_PIXEL;
    end else begin
      PLL_SRC_OUT <= next_src;
    end
  end

  // Divider output stays low unless the strap says an oscillator is fitted
  oscillator_divider_control u_div (
    .CLOCK_IN(CLOCK_IN),
    .RST_N_IN(RST_N_IN),
    .DIV4_IN(osc_div[`BIT_DIV4]),
    .EN_IN(strap_ext),
    .CLK_OUT(AUX_OUTPUT_PIN_TWO_OUT)
  );
endmodule
`default_nettype wire

/* tb/clkovr_regs_sva.sv */
// Checker for the clock override bank, bound onto clkovr_regs.
// Assumes the strap level is held steady through each run.
`default_nettype none
module clkovr_regs_sva
  import clkovr_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire clkovr_pkg::byte_t ADDR_IN,
  input wire clkovr_pkg::byte_t WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic PLL_OVERRIDE_IN,
  input wire logic STRAP_EXT_OSC_IN,
  input wire logic FRAME_START_IN,
  input wire clkovr_pkg::byte_t RDATA_OUT,
  input wire logic ERR_INJECT_OUT,
  input wire clkovr_pkg::pll_src_t PLL_SRC_OUT,
  input wire logic AUX_OUTPUT_PIN_TWO_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  logic div4;
  logic [2:0] up;
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    if (!RST_N_IN) div4 <= 1'b0;
    else if (WR_IN && ADDR_IN == 8'h29) div4 <= WDATA_IN[5];
  // Strap is only latched from the third edge, so wait it out
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    if (!RST_N_IN) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  a_div_two: assert property (up == 3'h7 && STRAP_EXT_OSC_IN && !div4
    && !$past(div4) && !$past(div4, 2)
    |-> AUX_OUTPUT_PIN_TWO_OUT != $past(AUX_OUTPUT_PIN_TWO_OUT)) else $error("div2 stall");
  a_div_four: assert property (up == 3'h7 && STRAP_EXT_OSC_IN && div4 && $past(div4, 4)
    |-> AUX_OUTPUT_PIN_TWO_OUT == !$past(AUX_OUTPUT_PIN_TWO_OUT, 2)) else $error("div4 bad");
  a_read_unmapped: assert property (RD_IN && !(ADDR_IN inside {8'h29, 8'h2A, 8'h2D, 8'h35})
    |=> RDATA_OUT == 8'h00) else $error("unmapped read");
  a_strap_bit: assert property (RD_IN && ADDR_IN == 8'h35 && up == 3'h7
    |=> RDATA_OUT[3] == STRAP_EXT_OSC_IN) else $error("strap bit");
  a_read_hold: assert property (!RD_IN |=> $stable(RDATA_OUT)) else $error("rdata moved");
  a_inject_frame: assert property (ERR_INJECT_OUT |-> $past(FRAME_START_IN))
    else $error("stray inject");
  a_src_override: assert property (PLL_SRC_OUT != SRC_PIXEL |-> $past(PLL_OVERRIDE_IN, 2)
    || $past(PLL_OVERRIDE_IN, 3) || $past(PLL_OVERRIDE_IN, 4)) else $error("src no override");
  a_src_legal: assert property (PLL_SRC_OUT != 2'b11) else $error("bad src");
endmodule
bind clkovr_regs clkovr_regs_sva i_clkovr_regs_sva (
  .CLOCK_IN(CLOCK_IN),
  .RST_N_IN(RST_N_IN),
  .ADDR_IN(ADDR_IN),
  .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN),
  .RD_IN(RD_IN),
  .PLL_OVERRIDE_IN(PLL_OVERRIDE_IN),
  .STRAP_EXT_OSC_IN(STRAP_EXT_OSC_IN),
  .FRAME_START_IN(FRAME_START_IN),
  .RDATA_OUT(RDATA_OUT),
  .ERR_INJECT_OUT(ERR_INJECT_OUT),
  .PLL_SRC_OUT(PLL_SRC_OUT),
  .AUX_OUTPUT_PIN_TWO_OUT(AUX_OUTPUT_PIN_TWO_OUT)
);
`default_nettype wire

/* tb/host_model.sv */
// Host on the local control port: byte writes and reads.
// Assumes strobes are sampled on the rising edge.
`default_nettype none
module host_model
  import clkovr_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire clkovr_pkg::byte_t RDATA_IN,
  output clkovr_pkg::byte_t ADDR_OUT,
  output clkovr_pkg::byte_t WDATA_OUT,
  output logic WR_OUT,
  output logic RD_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {ADDR_OUT, WDATA_OUT, WR_OUT, RD_OUT} = '0;
  task automatic wr(input byte_t a, input byte_t d);
    @(posedge CLOCK_IN);
    {ADDR_OUT, WDATA_OUT, WR_OUT} <= {a, d, 1'b1};
    @(posedge CLOCK_IN);
    // Data is not left standing after the strobe
    {WDATA_OUT, WR_OUT} <= {~d, 1'b0};
  endtask
  task automatic rd(input byte_t a, output byte_t d);
    @(posedge CLOCK_IN);
    {ADDR_OUT, RD_OUT} <= {a, 1'b1};
    @(posedge CLOCK_IN);
    RD_OUT <= 1'b0;
    @(posedge CLOCK_IN);
    #1 d = RDATA_IN;
  endtask
endmodule
`default_nettype wire

/* tb/clkovr_regs_tb.sv */
// Self-checking bench for the clock override bank.
// Assumes host_model and the bound checker are compiled first.
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module clkovr_regs_tb;
  import clkovr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, ovr = 1'b0, bist = 1'b0, frame = 1'b0, crc = 1'b0;
  logic wr, rd, inj, aux, aux_prev;
  logic strap = 1'b1;
  byte_t addr, wdata, rdata, got;
  pll_src_t src;
  int err_total = 0, n_tests = 0, n_inj = 0, n_rise = 0;
  byte_t rows [5][3] = '{'{8'h29, 8'h26, 8'h26}, '{8'h2A, 8'h55, 8'h00},
    '{8'h35, 8'h03, 8'h03}, '{8'h2D, 8'h05, 8'h05}, '{8'h40, 8'hAA, 8'h00}};
  always #12.5 clk = ~clk;
  always @(posedge clk) if (inj) n_inj++;
  host_model i_host_model(.CLOCK_IN(clk), .RDATA_IN(rdata), .ADDR_OUT(addr),
    .WDATA_OUT(wdata), .WR_OUT(wr), .RD_OUT(rd));
  clkovr_regs i_clkovr_regs(.CLOCK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .PLL_OVERRIDE_IN(ovr), .BIST_ACTIVE_IN(bist),
    .STRAP_EXT_OSC_IN(strap), .BC_CRC_ERR_IN(crc), .FRAME_START_IN(frame), .RDATA_OUT(rdata),
    .ERR_INJECT_OUT(inj), .PLL_SRC_OUT(src), .AUX_OUTPUT_PIN_TWO_OUT(aux));
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clk) {frame, crc} <= {1'b1, bist};
      @(posedge clk) {frame, crc} <= 2'b00;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic src_chk(input byte_t d, input pll_src_t e);
    i_host_model.wr(8'h35, d);
    repeat (5) @(posedge clk);
    #1 `CHK(src, e)
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (12000) @(posedge clk);
    err_total++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      repeat (4) @(posedge clk);
      i_host_model.rd(8'h29, got);
      `CHK(got, 8'h06)
      i_host_model.rd(8'h35, got);
      `CHK(got, 8'h01 | {4'h0, strap, 3'h0})
      `CHK(src, SRC_PIXEL)
      foreach (rows[i]) begin
        // The reserved location is only read, never written
        if (rows[i][0] != 8'h40) i_host_model.wr(rows[i][0], rows[i][1]);
        i_host_model.rd(rows[i][0], got);
        `CHK(got, rows[i][2] | ((rows[i][0] == 8'h35) ? {4'h0, strap, 3'h0} : 8'h00))
      end
      // Divide by four gives four rises in sixteen cycles; none without the strap
      n_rise = 0;
      aux_prev = aux;
      repeat (16) begin
        @(posedge clk);
        #1 if (aux && !aux_prev) n_rise++;
        aux_prev = aux;
      end
      `CHK(n_rise, strap ? 4 : 0)
      @(posedge clk) ovr <= 1'b1;
      src_chk(8'h02, SRC_EXT);
      src_chk(8'h03, SRC_OSC);
      src_chk(8'h00, SRC_PIXEL);
      n_inj = 0;
      i_host_model.wr(8'h2D, 8'h80);
      frames(2);
      `CHK(n_inj, 1)
      i_host_model.rd(8'h2D, got);
      `CHK(got, 8'h00)
      for (int k = 3; k >= 0; k -= 3) begin
        i_host_model.wr(8'h2D, 8'(k));
        n_inj = 0;
        @(posedge clk) bist <= 1'b1;
        repeat (4) @(posedge clk);
        frames(5);
        `CHK(n_inj, k)
        @(posedge clk) bist <= 1'b0;
        repeat (4) @(posedge clk);
        i_host_model.rd(8'h2A, got);
        `CHK(got, 8'h05)
      end
      @(posedge clk) {rst_n, ovr, strap} <= 3'b000;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
    end
    final_report;
  end
endmodule
`default_nettype wire
